/* bench/cjm_mem_model.sv */
// Flash ROM and small SRAM model on the far side of the shared bus
`timescale 1ns/100ps
`default_nettype none
module cjm_mem_model
  import cjm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [7:0] bus_lo_out,
  input wire logic [6:0] addr_hi_out,
  input wire logic write_enable,
  output logic [7:0] dedicated_inputs
);
  logic [7:0] flash [0:8191];
  logic [7:0] ram [0:31];
  logic [7:0] write_space [0:127];
  logic [7:0] float_pat = 8'h5A;

  initial
  begin
    foreach (flash[i]) flash[i] = 8'h00;
    foreach (ram[i]) ram[i] = 8'h00;
    foreach (write_space[i]) write_space[i] = 8'h00;
  end

  task automatic poke(input logic [14:0] a, input logic [7:0] d);
    if (!a[14])
      ram[a[4:0]] = d;
    else
      flash[a[12:0]] = d;
  endtask

  // Undriven bus toggles so a stale byte never looks valid
  always @(posedge clk_sys)
  begin
    float_pat <= ~float_pat;
    // Low pins carry data, so a store is placed by the high pins alone
    if (write_enable)
      write_space[addr_hi_out] <= bus_lo_out;
  end

  // Output enables straight from address bits, no decoder
  always_comb
    if (!addr_hi_out[6])
      dedicated_inputs = ram[bus_lo_out[4:0]];
    else if (!addr_hi_out[5])
      dedicated_inputs = flash[{addr_hi_out[4:0], bus_lo_out}];
    else
      dedicated_inputs = float_pat;
endmodule
`default_nettype wire

/* bench/cpu_jump_and_memory_bus_tb.sv */
// Self-checking bench for the jump decoder and shared memory bus
`timescale 1ns/100ps
`default_nettype none
module cpu_jump_and_memory_bus_tb;
  import cjm_pkg::*;
  logic clk_sys = 1'h0;
  logic reset_n = 1'h0;
  logic clk_en = 1'h1;
  logic flag_zero_in = 1'h0;
  logic flag_carry_in = 1'h0;
  logic [7:0] dedicated_inputs, bus_lo_out, bus_lo_oe;
  logic [6:0] addr_hi_out;
  logic write_enable, zero_flag, carry_flag, exp_carry, z, fresh;
  logic [15:0] pc;
  logic [15:0] exp_q[$];
  logic [31:0] rnd;
  int err_count = 0;
  int total_checks = 0;

  always #12.5 clk_sys = ~clk_sys;

  cjm_core i_cjm_core (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
    .dedicated_inputs(dedicated_inputs), .flag_load(1'h1), .flag_zero_in(flag_zero_in),
    .flag_carry_in(flag_carry_in), .bus_lo_out(bus_lo_out), .bus_lo_oe(bus_lo_oe),
    .addr_hi_out(addr_hi_out), .write_enable(write_enable), .zero_flag(zero_flag),
    .carry_flag(carry_flag));

  cjm_mem_model i_cjm_mem_model (.clk_sys(clk_sys), .bus_lo_out(bus_lo_out),
    .addr_hi_out(addr_hi_out), .write_enable(write_enable),
    .dedicated_inputs(dedicated_inputs));

  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    #1;
    rnd = $urandom;
    clk_en = rnd[1:0] != 2'h0;
    flag_carry_in = rnd[2];
  end

  // Compare once per new state; stalled cycles repeat the old one
  always @(posedge clk_sys or negedge reset_n)
    if (!reset_n)
    begin
      fresh <= 1'h1;
      exp_carry <= 1'h0;
    end
    else
    begin
      fresh <= clk_en;
      if (clk_en)
        exp_carry <= flag_carry_in;
    end

  always @(negedge clk_sys)
    if (reset_n)
      cmp("carry flag", {15'h0000, exp_carry}, {15'h0000, carry_flag});

  always @(negedge clk_sys)
    if (reset_n && fresh && exp_q.size() > 0)
    begin
      cmp("bus pins", exp_q.pop_front(), {write_enable, addr_hi_out, bus_lo_out});
      cmp("pin enable", 16'h00FF, {8'h00, bus_lo_oe});
    end

  task automatic run(input logic [15:0] w);
    logic [15:0] nxt;
    logic st;
    st = w[15:14] == OP_REG && w[13:11] == ALU_MOVR && w[1:0] == KIND_STORE;
    i_cjm_mem_model.poke(pc[14:0], w[15:8]);
    i_cjm_mem_model.poke(pc[14:0] + 15'h0001, w[7:0]);
    exp_q.push_back({1'h0, pc[14:0]});
    exp_q.push_back({1'h0, pc[14:0] + 15'h0001});
    if (!st)
      exp_q.push_back({1'h0, pc[14:0]});
    else
      repeat (2) exp_q.push_back({1'h1, REG_RESET[6:0], REG_RESET});
    nxt = pc + PC_STEP;
    if (w[15:14] == OP_JUMP_IMM && (w[13:12] == COND_ALWAYS || w[13:12] == {~z, z}))
      nxt = (pc & JUMP_KEEP_MASK) | {3'h0, w[11:0], 1'h0};
    if (w[15:14] == OP_JUMP_PAIR)
      nxt = {REG_RESET, REG_RESET};
    pc = nxt;
  endtask

  task automatic phase(input logic zf);
    int k;
    @(posedge clk_sys);
    #1;
    reset_n = 1'h0;
    flag_zero_in = zf;
    z = zf;
    pc = PC_RESET;
    i_cjm_mem_model.write_space[REG_RESET[6:0]] = 8'h00;
    for (k = 0; k < 4; k++)
    begin
      run({2'h0, k[1:0], 4'(k + 1), 1'h0, 7'($urandom)});
      run({5'h13, 3'($urandom), 3'h0, 1'($urandom), 2'h0, KIND_STORE});
    end
    run({OP_JUMP_PAIR, 14'($urandom)});
    run({5'h13, 3'($urandom), 3'h0, 1'($urandom), 2'h0, KIND_STORE});
    repeat (16) @(posedge clk_sys);
    #1;
    reset_n = 1'h1;
    for (k = 0; k < 2000 && exp_q.size() > 0; k++)
      @(posedge clk_sys);
    if (exp_q.size() > 0)
    begin
      err_count++;
      give_verdict();
    end
    @(negedge clk_sys);
    cmp("zero flag", {15'h0000, zf}, {15'h0000, zero_flag});
    cmp("stored byte", {8'h00, REG_RESET}, {8'h00, i_cjm_mem_model.write_space[REG_RESET[6:0]]});
  endtask

  initial
  begin
    void'($urandom(4));
    phase(1'h1);
    phase(1'h0);
    give_verdict();
  end
endmodule
`default_nettype wire

/* core/cjm_core.sv */
// Jump execution, fetch sequencing and shared external memory bus pins
`timescale 1ns/100ps
`default_nettype none
module cjm_core
  import cjm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic [7:0] dedicated_inputs,
  input wire logic flag_load,
  input wire logic flag_zero_in,
  input wire logic flag_carry_in,
  output logic [7:0] bus_lo_out,
  output logic [7:0] bus_lo_oe,
  output logic [6:0] addr_hi_out,
  output logic write_enable,
  output logic zero_flag,
  output logic carry_flag
);
  import cjm_pkg::*;

  cjm_state_t state_reg, state_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] instr_hi_reg;
  logic [15:0] instr_reg;
  logic [7:0] reg_file_reg [NUM_REGS];
  logic [15:0] cur_instr;
  logic [15:0] pointer_pair_high, pointer_pair_low, store_ptr;
  logic is_jump_imm, is_jump_pair, is_store, jump_taken, store_low;
  logic [15:0] jump_target;
  logic [2:0] store_src;
  logic [15:0] bus_addr_next;
  logic store_next;
  logic started_reg;

  always_comb
  begin
    pointer_pair_high = {reg_file_reg[REG_G], reg_file_reg[REG_H]};
    pointer_pair_low = {reg_file_reg[REG_E], reg_file_reg[REG_F]};
    // Instruction word is complete one cycle early so the store can steer the pins in time
    cur_instr = (state_reg == ST_FETCH_LO) ? {instr_hi_reg, dedicated_inputs} : instr_reg;
    store_ptr = store_low ? pointer_pair_low : pointer_pair_high;
  end

  cjm_decode u_decode (
    .instr(cur_instr),
    .pc(pc_reg),
    .pointer_pair_high(pointer_pair_high),
    .zero_flag(zero_flag),
    .is_jump_imm(is_jump_imm),
    .is_jump_pair(is_jump_pair),
    .is_store(is_store),
    .jump_taken(jump_taken),
    .jump_target(jump_target),
    .store_src(store_src),
    .store_use_low_pair(store_low)
  );

  always_comb
  begin
    state_next = state_reg;
    pc_next = pc_reg;
    case (state_reg)
      ST_FETCH_HI: state_next = ST_FETCH_LO;
      ST_FETCH_LO: state_next = ST_EXEC;
      ST_EXEC:
      begin
        state_next = is_store ? ST_WBACK : ST_FETCH_HI;
        pc_next = jump_taken ? jump_target : pc_reg + PC_STEP;
      end
      ST_WBACK: state_next = ST_FETCH_HI;
      default: state_next = ST_FETCH_HI;
    endcase
    store_next = is_store && (state_next == ST_EXEC || state_next == ST_WBACK);
    case (state_next)
      ST_FETCH_HI: bus_addr_next = pc_next;
      ST_FETCH_LO: bus_addr_next = pc_reg + BYTE_STEP;
      ST_EXEC: bus_addr_next = is_store ? store_ptr : pc_reg;
      ST_WBACK: bus_addr_next = store_ptr;
      default: bus_addr_next = pc_reg;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= ST_FETCH_HI;
      pc_reg <= PC_RESET;
      started_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      started_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      instr_hi_reg <= REG_RESET;
      instr_reg <= {REG_RESET, REG_RESET};
    end
    else if (clk_en)
    begin
      if (state_reg == ST_FETCH_HI)
        instr_hi_reg <= dedicated_inputs;
      if (state_reg == ST_FETCH_LO)
        instr_reg <= cur_instr;
    end
  end

  // No form inside this block writes the file; the pointer pairs keep their reset value
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < NUM_REGS; i++)
        reg_file_reg[i] <= REG_RESET;
    end
  end

  // Flags come from the arithmetic unit; jumps only read them
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      zero_flag <= 1'b0;
      carry_flag <= 1'b0;
    end
    else if (clk_en && flag_load)
    begin
      zero_flag <= flag_zero_in;
      carry_flag <= flag_carry_in;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bus_lo_out <= PC_RESET[7:0];
      bus_lo_oe <= 8'hFF;
      addr_hi_out <= PC_RESET[ADDR_HI_MSB:ADDR_HI_LSB];
      write_enable <= 1'b0;
    end
    else if (clk_en)
    begin
      // Low address byte is given up to data during stores
      bus_lo_out <= store_next ? reg_file_reg[store_src] : bus_addr_next[7:0];
      bus_lo_oe <= 8'hFF;
      addr_hi_out <= bus_addr_next[ADDR_HI_MSB:ADDR_HI_LSB];
      write_enable <= store_next;
    end
  end

  sequence s_store_cycles;
    write_enable && bus_lo_out == $past(reg_file_reg[store_src]) ##1 write_enable;
  endsequence

  property p_jump_imm_target;
    @(posedge clk_sys iff clk_en) disable iff (!reset_n)
    (state_reg == ST_EXEC && is_jump_imm && jump_taken)
      |=> pc_reg == (($past(pc_reg) & JUMP_KEEP_MASK) | {3'h0, $past(instr_reg[IMM_W-1:0]), 1'b0});
  endproperty
  a_jump_imm_target: assert property (p_jump_imm_target) else $error("absolute jump target wrong");

  property p_cond_decode;
    @(posedge clk_sys iff clk_en) disable iff (!reset_n)
    (state_reg == ST_EXEC && instr_reg[OP_HI:OP_LO] == OP_JUMP_IMM)
      |-> jump_taken == ((instr_reg[COND_HI:COND_LO] == COND_ALWAYS)
        || (instr_reg[COND_HI:COND_LO] == COND_ZERO && zero_flag)
        || (instr_reg[COND_HI:COND_LO] == COND_NONZERO && !zero_flag));
  endproperty
  a_cond_decode: assert property (p_cond_decode) else $error("jump condition decoded wrong");

  property p_not_taken;
    @(posedge clk_sys iff clk_en) disable iff (!reset_n)
    (state_reg == ST_EXEC && is_jump_imm && !jump_taken)
      |=> pc_reg == $past(pc_reg) + PC_STEP && state_reg == ST_FETCH_HI && !write_enable;
  endproperty
  a_not_taken: assert property (p_not_taken) else $error("untaken jump did not step");

  property p_jump_pair;
    @(posedge clk_sys iff clk_en) disable iff (!reset_n)
    (state_reg == ST_EXEC && instr_reg[OP_HI:OP_LO] == OP_JUMP_PAIR) |=> pc_reg == $past(pointer_pair_high);
  endproperty
  a_jump_pair: assert property (p_jump_pair) else $error("pointer jump went wrong");

  property p_store_pins;
    @(posedge clk_sys iff clk_en) disable iff (!reset_n)
    (state_reg == ST_FETCH_LO && is_store) |=> s_store_cycles ##1 !write_enable;
  endproperty
  a_store_pins: assert property (p_store_pins) else $error("store data or enable timing wrong");

  property p_we_only_store;
    @(posedge clk_sys iff clk_en) disable iff (!reset_n)
    write_enable |-> (state_reg == ST_EXEC || state_reg == ST_WBACK) && is_store;
  endproperty
  a_we_only_store: assert property (p_we_only_store) else $error("write enable outside store");

  property p_fetch_addr;
    @(posedge clk_sys iff clk_en) disable iff (!reset_n)
    state_reg == ST_FETCH_HI |-> {addr_hi_out, bus_lo_out} == pc_reg[ADDR_HI_MSB:0] && &bus_lo_oe;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch address not on pins");

  property p_reset_state;
    @(posedge clk_sys) disable iff (!reset_n)
    !started_reg |-> pc_reg == PC_RESET && pointer_pair_high == {REG_RESET, REG_RESET};
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset values wrong");
endmodule
`default_nettype wire

/* core/cjm_decode.sv */
// Combinational decoder for the jump forms and the register store form
`timescale 1ns/100ps
`default_nettype none
module cjm_decode
  import cjm_pkg::*;
(
  input wire logic [15:0] instr,
  input wire logic [15:0] pc,
  input wire logic [15:0] pointer_pair_high,
  input wire logic zero_flag,
  output logic is_jump_imm,
  output logic is_jump_pair,
  output logic is_store,
  output logic jump_taken,
  output logic [15:0] jump_target,
  output logic [2:0] store_src,
  output logic store_use_low_pair
);
  logic [1:0] cond;
  logic [IMM_W-1:0] target_immediate;

  always_comb
  begin
    cond = instr[COND_HI:COND_LO];
    target_immediate = instr[IMM_W-1:0];
    is_jump_imm = (instr[OP_HI:OP_LO] == OP_JUMP_IMM);
    is_jump_pair = (instr[OP_HI:OP_LO] == OP_JUMP_PAIR);
    is_store = (instr[OP_HI:OP_LO] == OP_REG) && (instr[ALU_HI:ALU_LO] == ALU_MOVR)
      && (instr[KIND_HI:KIND_LO] == KIND_STORE);
    store_src = instr[DST_HI:DST_LO];
    store_use_low_pair = instr[MODE_BIT];
    jump_taken = 1'b0;
    jump_target = pc;
    if (is_jump_imm)
    begin
      case (cond)
        COND_ZERO: jump_taken = zero_flag;
        COND_NONZERO: jump_taken = !zero_flag;
        COND_ALWAYS: jump_taken = 1'b1;
        default: jump_taken = 1'b0;
      endcase
      jump_target = (pc & JUMP_KEEP_MASK) | {3'h0, target_immediate, 1'b0};
    end
    else if (is_jump_pair)
    begin
      jump_taken = 1'b1;
      jump_target = pointer_pair_high;
    end
  end
endmodule
`default_nettype wire

/* core/cjm_pkg.sv */
// Shared constants and types for the jump decoder and memory bus block
package cjm_pkg;
  localparam logic [15:0] PC_RESET = 16'h4000;
  localparam logic [7:0] REG_RESET = 8'h80;
  localparam logic [15:0] PC_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;
  localparam logic [15:0] JUMP_KEEP_MASK = 16'hE000;
  localparam int NUM_REGS = 8;
  localparam int IMM_W = 12;
  localparam int OP_HI = 15;
  localparam int OP_LO = 14;
  localparam int COND_HI = 13;
  localparam int COND_LO = 12;
  localparam int ALU_HI = 13;
  localparam int ALU_LO = 11;
  localparam int DST_HI = 10;
  localparam int DST_LO = 8;
  localparam int MODE_BIT = 4;
  localparam int KIND_HI = 1;
  localparam int KIND_LO = 0;
  localparam logic [1:0] OP_JUMP_IMM = 2'h0;
  localparam logic [1:0] OP_JUMP_PAIR = 2'h1;
  localparam logic [1:0] OP_REG = 2'h2;
  localparam logic [1:0] COND_ZERO = 2'h1;
  localparam logic [1:0] COND_NONZERO = 2'h2;
  localparam logic [1:0] COND_ALWAYS = 2'h3;
  localparam logic [2:0] ALU_MOVR = 3'h3;
  localparam logic [1:0] KIND_STORE = 2'h1;
  localparam logic [2:0] REG_E = 3'h4;
  localparam logic [2:0] REG_F = 3'h5;
  localparam logic [2:0] REG_G = 3'h6;
  localparam logic [2:0] REG_H = 3'h7;
  localparam int ADDR_HI_MSB = 14;
  localparam int ADDR_HI_LSB = 8;
  typedef enum logic [1:0] {ST_FETCH_HI, ST_FETCH_LO, ST_EXEC, ST_WBACK} cjm_state_t;
endpackage
